/* logic/iosad_io_space_access_decode.sv */
// i/o register space decoder with bit access and extended area routing
//
// What this block does
// - low 32 i/o addresses take bit set/clear
// - low 32 i/o addresses support bit skip tests
// - some flags clear on written one only
// - bit set/clear touches only the addressed bit
// - i/o ops use 6-bit addresses 0x00-0x3f
// - data space sees i/o at address plus 0x20
// - extended area 0x60-0xff only via load/store
`timescale 1ns/1ps

module iosad_io_space_access_decode
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // dedicated i/o instruction port
  input wire logic io_valid,
  input wire iosad_pkg::iosad_io_op_t io_op,
  input wire logic [5:0] io_addr,
  input wire logic [2:0] io_bit,
  input wire logic [7:0] io_wdata,
  // load/store data space port
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  // answers to the core
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic skip_valid,
  output logic skip_taken,
  output logic access_error,
  // live peripheral levels
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_c_pins,
  input wire logic [7:0] port_d_pins,
  input wire logic [7:0] port_e_pins,
  input wire logic [1:0] spi_status_live,
  input wire logic acomp_level,
  // flag set events from peripherals
  input wire logic [7:0] timer0_evt,
  input wire logic [7:0] timer1_evt,
  input wire logic [7:0] timer2_evt,
  input wire logic [7:0] ext_irq_evt,
  input wire logic [7:0] pin_chg_evt,
  input wire logic acomp_evt,
  // extended i/o area
  output logic ext_rd,
  output logic ext_wr,
  output logic [7:0] ext_addr,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata,
  // register contents seen by the peripherals
  output logic [63:0][7:0] io_reg_image
);
  import iosad_pkg::*;

  // ****************************************************************
  // bit layout of the map
  // ****************************************************************

  // bits stored and written plainly; missing bits are reserved unless a flag or live bit
  function automatic logic [7:0] rw_mask(input logic [5:0] a);
    case (a)
      IOSAD_PORT_B_DIRECTION, IOSAD_PORT_B_OUTPUT: rw_mask = 8'hff;
      IOSAD_PORT_C_DIRECTION, IOSAD_PORT_C_OUTPUT: rw_mask = 8'h7f;
      IOSAD_PORT_D_DIRECTION, IOSAD_PORT_D_OUTPUT: rw_mask = 8'hff;
      IOSAD_PORT_E_DIRECTION, IOSAD_PORT_E_OUTPUT: rw_mask = 8'h0f;
      IOSAD_EXT_IRQ_MASK: rw_mask = 8'h03;
      IOSAD_SCRATCH_REG_0: rw_mask = 8'hff;
      IOSAD_EEPROM_CONTROL: rw_mask = 8'h3f;
      IOSAD_EEPROM_DATA, IOSAD_EEPROM_ADDR_LOW: rw_mask = 8'hff;
      IOSAD_EEPROM_ADDR_HIGH: rw_mask = 8'hff;
      IOSAD_TIMER_PRESCALER_CTRL: rw_mask = 8'h83;
      IOSAD_TIMER0_CTRL_A: rw_mask = 8'hf3;
      IOSAD_TIMER0_CTRL_B: rw_mask = 8'hcf;
      IOSAD_TIMER0_COUNT, IOSAD_TIMER0_COMPARE_A: rw_mask = 8'hff;
      IOSAD_TIMER0_COMPARE_B: rw_mask = 8'hff;
      IOSAD_SCRATCH_REG_1, IOSAD_SCRATCH_REG_2: rw_mask = 8'hff;
      IOSAD_SPI_CONTROL, IOSAD_SPI_DATA: rw_mask = 8'hff;
      IOSAD_SPI_STATUS: rw_mask = 8'h01;
      IOSAD_ANALOG_COMP_OUTPUT_CTRL: rw_mask = 8'h01;
      IOSAD_ANALOG_COMP_CTRL_STATUS: rw_mask = 8'hcf;
      default: rw_mask = 8'h00;
    endcase
  endfunction

  // flags set by hardware and cleared by a written one
  function automatic logic [7:0] w1c_mask(input logic [5:0] a);
    case (a)
      IOSAD_TIMER0_IRQ_FLAGS: w1c_mask = 8'h07;
      IOSAD_TIMER1_IRQ_FLAGS: w1c_mask = 8'h27;
      IOSAD_TIMER2_IRQ_FLAGS: w1c_mask = 8'h07;
      IOSAD_PIN_CHANGE_IRQ_FLAGS: w1c_mask = 8'h07;
      IOSAD_EXT_IRQ_FLAGS: w1c_mask = 8'h03;
      IOSAD_ANALOG_COMP_CTRL_STATUS: w1c_mask = 8'h10;
      default: w1c_mask = 8'h00;
    endcase
  endfunction

  // bits that show a live level and ignore writes
  function automatic logic [7:0] hw_mask(input logic [5:0] a);
    case (a)
      IOSAD_PORT_B_INPUT, IOSAD_PORT_D_INPUT: hw_mask = 8'hff;
      IOSAD_PORT_C_INPUT: hw_mask = 8'h7f;
      IOSAD_PORT_E_INPUT: hw_mask = 8'h0f;
      IOSAD_SPI_STATUS: hw_mask = 8'hc0;
      IOSAD_ANALOG_COMP_CTRL_STATUS: hw_mask = 8'h20;
      default: hw_mask = 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // request decode
  // ****************************************************************

  logic req_open;
  logic io_take;
  logic mem_take;
  logic mem_low;
  logic mem_io;
  logic mem_ext;
  logic [5:0] mem_idx;
  logic bit_ok;
  logic bit_op;
  logic bit_hit;
  logic bit_set;
  logic [7:0] bit_sel;
  logic full_hit;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic rd_hit;
  logic [5:0] rd_idx;
  logic test_hit;
  logic [7:0] live [64];
  logic [7:0] evt [64];
  logic [7:0] read_val [64];

  // the cycle after an extended read carries its answer, so no request
  assign req_open = !ext_rd;
  assign io_take = io_valid && req_open;
  assign mem_take = mem_valid && req_open && !io_valid;

  // data space windows: core registers, i/o, extended area
  assign mem_low = mem_addr < IOSAD_MEM_IO_BASE;
  assign mem_ext = mem_addr >= IOSAD_MEM_EXT_BASE;
  assign mem_io = !mem_low && !mem_ext;
  assign mem_idx = 6'(mem_addr - IOSAD_MEM_IO_BASE);

  // bit instructions only reach the lower half of i/o space
  assign bit_ok = io_addr < IOSAD_BIT_LIMIT;
  assign bit_set = io_op == IOSAD_OP_SET_BIT;
  assign bit_op = bit_set || io_op == IOSAD_OP_CLR_BIT;
  assign bit_hit = io_take && bit_op && bit_ok;
  assign bit_sel = 8'h01 << io_bit;

  // whole-register writes from either port
  assign full_hit = (io_take && io_op == IOSAD_OP_OUT) ||
                    (mem_take && mem_write && mem_io);
  assign wr_idx = io_take ? io_addr : mem_idx;
  assign wr_data = io_take ? io_wdata : mem_wdata;

  // whole-register reads; core register window reads as zero
  assign rd_hit = (io_take && io_op == IOSAD_OP_IN) ||
                  (mem_take && !mem_write && !mem_ext);
  assign rd_idx = io_take ? io_addr : mem_idx;
  assign test_hit = io_take &&
    (io_op == IOSAD_OP_SKIP_HIGH || io_op == IOSAD_OP_SKIP_LOW);

  // routing of peripheral levels and events onto addresses
  always_comb
  begin
    for (int i = 0; i < 64; i++)
    begin
      live[i] = 8'h00;
      evt[i] = 8'h00;
    end
    live[IOSAD_PORT_B_INPUT] = port_b_pins;
    live[IOSAD_PORT_C_INPUT] = port_c_pins;
    live[IOSAD_PORT_D_INPUT] = port_d_pins;
    live[IOSAD_PORT_E_INPUT] = port_e_pins;
    live[IOSAD_SPI_STATUS] = 8'(spi_status_live) << IOSAD_SPI_LIVE_LSB;
    live[IOSAD_ANALOG_COMP_CTRL_STATUS] = 8'(acomp_level) << IOSAD_ACO_BIT;
    evt[IOSAD_TIMER0_IRQ_FLAGS] = timer0_evt;
    evt[IOSAD_TIMER1_IRQ_FLAGS] = timer1_evt;
    evt[IOSAD_TIMER2_IRQ_FLAGS] = timer2_evt;
    evt[IOSAD_EXT_IRQ_FLAGS] = ext_irq_evt;
    evt[IOSAD_PIN_CHANGE_IRQ_FLAGS] = pin_chg_evt;
    evt[IOSAD_ANALOG_COMP_CTRL_STATUS] = 8'(acomp_evt) << IOSAD_ACI_BIT;
  end

  // ****************************************************************
  // register storage, one entry per i/o address
  // ****************************************************************

  for (genvar a = 0; a < 64; a++)
  begin : g_reg
    localparam logic [5:0] ADDR = 6'(a);
    localparam logic [7:0] RW = rw_mask(ADDR);
    localparam logic [7:0] W1 = w1c_mask(ADDR);
    localparam logic [7:0] HW = hw_mask(ADDR);
    logic [7:0] st;
    logic [7:0] clr;
    logic [7:0] next_val;

    // write, bit op and flag events merged; a flag event beats its clear
    always_comb
    begin
      st = io_reg_image[a];
      clr = 8'h00;
      if (full_hit && wr_idx == ADDR)
      begin
        st = (st & ~RW) | (wr_data & RW);
        clr = wr_data & W1;
      end
      else if (bit_hit && io_addr == ADDR)
      begin
        // only the selected bit moves; a set on a flag is a one-write
        if (bit_set)
        begin
          st = st | (bit_sel & RW);
          clr = bit_sel & W1;
        end
        else
        begin
          st = st & ~(bit_sel & RW);
        end
      end
      next_val = (st & ~clr & (RW | W1)) | (evt[a] & W1);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
        io_reg_image[a] <= IOSAD_REG_RST;
      else
        io_reg_image[a] <= next_val;
    end

    // reserved bits and addresses read as zero
    assign read_val[a] = (io_reg_image[a] & (RW | W1)) | (live[a] & HW);
  end

  // ****************************************************************
  // answers to the core
  // ****************************************************************

  // read data, one cycle for i/o, two for the extended area
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end
    else
    begin
      rd_valid <= rd_hit || ext_rd;
      if (ext_rd)
        rd_data <= ext_rdata;
      else if (rd_hit && !(mem_take && mem_low))
        rd_data <= read_val[rd_idx];
      else
        rd_data <= 8'h00;
    end
  end

  // bit tests; out of the lower half they never skip
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      skip_valid <= 1'b0;
      skip_taken <= 1'b0;
    end
    else
    begin
      skip_valid <= test_hit;
      skip_taken <= test_hit && bit_ok &&
        (read_val[io_addr][io_bit] == (io_op == IOSAD_OP_SKIP_HIGH));
    end
  end

  // misuse flagged, never acted on
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      access_error <= 1'b0;
    else
      access_error <= (io_take && (bit_op || test_hit) && !bit_ok) ||
        (full_hit && (rw_mask(wr_idx) | w1c_mask(wr_idx) |
                      hw_mask(wr_idx)) == 8'h00) ||
        (mem_take && mem_low);
  end

  // extended area strobes; i/o ops have no path here
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ext_rd <= 1'b0;
      ext_wr <= 1'b0;
      ext_addr <= 8'h00;
      ext_wdata <= 8'h00;
    end
    else
    begin
      ext_rd <= mem_take && mem_ext && !mem_write;
      ext_wr <= mem_take && mem_ext && mem_write;
      if (mem_take && mem_ext)
      begin
        ext_addr <= mem_addr;
        ext_wdata <= mem_wdata;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  bit_set_low_a: assert property (
    bit_hit && bit_set && (rw_mask(io_addr) & bit_sel) != 8'h00
    |=> io_reg_image[$past(io_addr)][$past(io_bit)])
    else $error("bit set did not set the bit");

  bit_clr_low_a: assert property (
    bit_hit && !bit_set && (rw_mask(io_addr) & bit_sel) != 8'h00
    |=> !io_reg_image[$past(io_addr)][$past(io_bit)])
    else $error("bit clear did not clear the bit");

  skip_test_a: assert property (
    test_hit && bit_ok
    |=> skip_valid && skip_taken ==
        ($past(read_val[io_addr][io_bit]) ==
         ($past(io_op) == IOSAD_OP_SKIP_HIGH)))
    else $error("skip result wrong");

  flag_w1c_a: assert property (
    full_hit && evt[wr_idx] == 8'h00
    |=> (io_reg_image[$past(wr_idx)] & w1c_mask($past(wr_idx))) ==
        $past(io_reg_image[wr_idx] & ~wr_data & w1c_mask(wr_idx)))
    else $error("flag write did not act as write-one-clear");

  bit_only_a: assert property (
    bit_hit && evt[io_addr] == 8'h00
    |=> (io_reg_image[$past(io_addr)] & ~$past(bit_sel)) ==
        $past(io_reg_image[io_addr] & ~bit_sel))
    else $error("bit op disturbed other bits");

  io_read_a: assert property (
    io_take && io_op == IOSAD_OP_IN
    |=> rd_valid && rd_data == $past(read_val[io_addr]))
    else $error("i/o read data wrong");

  mem_map_a: assert property (
    mem_take && !mem_write && mem_io
    |=> rd_valid && rd_data == $past(read_val[mem_idx]))
    else $error("data space read not offset by 0x20");

  ext_only_mem_a: assert property (
    io_valid |=> !ext_rd && !ext_wr)
    else $error("i/o op reached the extended area");

  ext_read_a: assert property (
    mem_take && !mem_write && mem_ext
    |=> ext_rd ##1 rd_valid && rd_data == $past(ext_rdata))
    else $error("extended read not answered");

  reserved_zero_a: assert property (
    io_take && io_op == IOSAD_OP_IN &&
    (rw_mask(io_addr) | w1c_mask(io_addr) | hw_mask(io_addr)) == 8'h00
    |=> rd_data == 8'h00)
    else $error("reserved address read nonzero");

  bit_set_c: cover property (bit_hit && bit_set ##1 rd_hit);
  flag_clear_c: cover property (full_hit && (wr_data & w1c_mask(wr_idx))
                                != 8'h00);
  skip_c: cover property (test_hit ##1 skip_taken);
  ext_c: cover property (ext_rd ##1 rd_valid);

endmodule

/* logic/iosad_pkg.sv */
// package: offsets, field positions and codes of the i/o space decoder
package iosad_pkg;

  // i/o offsets (6-bit i/o address space)
  localparam logic [5:0] IOSAD_PORT_B_INPUT = 6'h03;
  localparam logic [5:0] IOSAD_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] IOSAD_PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] IOSAD_PORT_C_INPUT = 6'h06;
  localparam logic [5:0] IOSAD_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] IOSAD_PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] IOSAD_PORT_D_INPUT = 6'h09;
  localparam logic [5:0] IOSAD_PORT_D_DIRECTION = 6'h0a;
  localparam logic [5:0] IOSAD_PORT_D_OUTPUT = 6'h0b;
  localparam logic [5:0] IOSAD_PORT_E_INPUT = 6'h0c;
  localparam logic [5:0] IOSAD_PORT_E_DIRECTION = 6'h0d;
  localparam logic [5:0] IOSAD_PORT_E_OUTPUT = 6'h0e;
  localparam logic [5:0] IOSAD_TIMER0_IRQ_FLAGS = 6'h15;
  localparam logic [5:0] IOSAD_TIMER1_IRQ_FLAGS = 6'h16;
  localparam logic [5:0] IOSAD_TIMER2_IRQ_FLAGS = 6'h17;
  localparam logic [5:0] IOSAD_PIN_CHANGE_IRQ_FLAGS = 6'h1b;
  localparam logic [5:0] IOSAD_EXT_IRQ_FLAGS = 6'h1c;
  localparam logic [5:0] IOSAD_EXT_IRQ_MASK = 6'h1d;
  localparam logic [5:0] IOSAD_SCRATCH_REG_0 = 6'h1e;
  localparam logic [5:0] IOSAD_EEPROM_CONTROL = 6'h1f;
  localparam logic [5:0] IOSAD_EEPROM_DATA = 6'h20;
  localparam logic [5:0] IOSAD_EEPROM_ADDR_LOW = 6'h21;
  localparam logic [5:0] IOSAD_EEPROM_ADDR_HIGH = 6'h22;
  localparam logic [5:0] IOSAD_TIMER_PRESCALER_CTRL = 6'h23;
  localparam logic [5:0] IOSAD_TIMER0_CTRL_A = 6'h24;
  localparam logic [5:0] IOSAD_TIMER0_CTRL_B = 6'h25;
  localparam logic [5:0] IOSAD_TIMER0_COUNT = 6'h26;
  localparam logic [5:0] IOSAD_TIMER0_COMPARE_A = 6'h27;
  localparam logic [5:0] IOSAD_TIMER0_COMPARE_B = 6'h28;
  localparam logic [5:0] IOSAD_SCRATCH_REG_1 = 6'h2a;
  localparam logic [5:0] IOSAD_SCRATCH_REG_2 = 6'h2b;
  localparam logic [5:0] IOSAD_SPI_CONTROL = 6'h2c;
  localparam logic [5:0] IOSAD_SPI_STATUS = 6'h2d;
  localparam logic [5:0] IOSAD_SPI_DATA = 6'h2e;
  localparam logic [5:0] IOSAD_ANALOG_COMP_OUTPUT_CTRL = 6'h2f;
  localparam logic [5:0] IOSAD_ANALOG_COMP_CTRL_STATUS = 6'h30;

  // address windows
  localparam logic [5:0] IOSAD_BIT_LIMIT = 6'h20;
  localparam logic [7:0] IOSAD_MEM_IO_BASE = 8'h20;
  localparam logic [7:0] IOSAD_MEM_EXT_BASE = 8'h60;
  localparam logic [7:0] IOSAD_MEM_EXT_TOP = 8'hff;

  // field positions inside mixed registers
  localparam int IOSAD_SPI_LIVE_LSB = 6;
  localparam int IOSAD_ACO_BIT = 5;
  localparam int IOSAD_ACI_BIT = 4;

  // reset value of every stored bit
  localparam logic [7:0] IOSAD_REG_RST = 8'h00;

  // dedicated i/o operations issued by the core
  typedef enum logic [2:0] {
    IOSAD_OP_IN = 3'h0,
    IOSAD_OP_OUT = 3'h1,
    IOSAD_OP_SET_BIT = 3'h2,
    IOSAD_OP_CLR_BIT = 3'h3,
    IOSAD_OP_SKIP_HIGH = 3'h4,
    IOSAD_OP_SKIP_LOW = 3'h5
  } iosad_io_op_t;

endpackage

/* sim/iosad_ext_area_model.sv */
// model of the extended i/o area behind load/store traffic
`timescale 1ns/1ps

module iosad_ext_area_model
(
  // clock
  input wire logic clk_sys,
  // strobes from the decoder
  input wire logic ext_rd,
  input wire logic ext_wr,
  input wire logic [7:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  // answer
  output logic [7:0] ext_rdata
);
  logic [7:0] cells [256];

  // known pattern so every read has a predictable value
  initial
  begin
    for (int i = 0; i < 256; i++)
      cells[i] = 8'(i) ^ 8'h5a;
  end

  // store lands at the edge that ends the write pulse
  always @(posedge clk_sys)
    if (ext_wr)
      cells[ext_addr] <= ext_wdata;

  // inverse outside the read strobe, so a late sample cannot pass by luck
  assign ext_rdata = ext_rd ? cells[ext_addr] : ~cells[ext_addr];
endmodule

/* sim/iosad_io_space_access_decode_tb_top.sv */
// self-checking bench for the i/o space decoder
`timescale 1ns/1ps

module iosad_io_space_access_decode_tb_top;
  import iosad_pkg::*;

  typedef struct {
    logic is_mem;
    iosad_io_op_t op;
    logic [7:0] addr;
    logic [2:0] bit_no;
    logic [7:0] wdata;
    logic [7:0] exp;
    logic exp_err;
  } iosad_row_t;

  logic clk_sys, rst, io_valid, mem_valid, mem_write;
  iosad_io_op_t io_op;
  logic [5:0] io_addr;
  logic [2:0] io_bit;
  logic [7:0] io_wdata, mem_addr, mem_wdata, rd_data;
  logic rd_valid, skip_valid, skip_taken, access_error;
  logic [7:0] port_b_pins, port_c_pins, port_d_pins, port_e_pins;
  logic [1:0] spi_status_live;
  logic acomp_level, acomp_evt, ext_rd, ext_wr;
  logic [7:0] timer0_evt, timer1_evt, timer2_evt, ext_irq_evt, pin_chg_evt;
  logic [7:0] ext_addr, ext_wdata, ext_rdata;
  logic [63:0][7:0] io_reg_image;
  int err_count, compares;
  logic err_seen, ext_seen;
  logic [1:0] skip_tk;
  logic [7:0] rd_val, got, ia;
  iosad_row_t rows [$];

  iosad_io_space_access_decode dut
  (
    .clk_sys, .rst, .io_valid, .io_op, .io_addr, .io_bit, .io_wdata,
    .mem_valid, .mem_write, .mem_addr, .mem_wdata, .rd_valid, .rd_data,
    .skip_valid, .skip_taken, .access_error, .port_b_pins, .port_c_pins,
    .port_d_pins, .port_e_pins, .spi_status_live, .acomp_level,
    .timer0_evt, .timer1_evt, .timer2_evt, .ext_irq_evt, .pin_chg_evt,
    .acomp_evt, .ext_rd, .ext_wr, .ext_addr, .ext_wdata, .ext_rdata,
    .io_reg_image
  );

  iosad_ext_area_model far_end
  (
    .clk_sys, .ext_rd, .ext_wr, .ext_addr, .ext_wdata, .ext_rdata
  );

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask

  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // set request lines only; caller owns the edges
  task automatic put(input logic iv, input iosad_io_op_t op,
    input logic [5:0] a, input logic [7:0] d, input logic mv,
    input logic mw, input logic [7:0] ma);
    io_valid = iv;
    io_op = op;
    io_addr = a;
    io_wdata = d;
    mem_valid = mv;
    mem_write = mw;
    mem_addr = ma;
    mem_wdata = d;
  endtask

  // bounded window over the answer strobes after a request ends
  task automatic watch();
    rd_val = 'x;
    skip_tk = 'x;
    {err_seen, ext_seen} = 2'h0;
    for (int k = 0; k < 4; k++)
    begin
      if (rd_valid === 1'b1)
        rd_val = rd_data;
      if (skip_valid === 1'b1)
        skip_tk = {1'b1, skip_taken};
      err_seen |= access_error;
      ext_seen |= ext_rd | ext_wr;
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic add(input logic m, input iosad_io_op_t op,
    input logic [7:0] a, input logic [2:0] b, input logic [7:0] d,
    input logic [7:0] e, input logic x);
    rows.push_back('{m, op, a, b, d, e, x});
  endtask

  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // a hung run still reaches the verdict
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    io_bit = 3'h0;
    put(1'b0, IOSAD_OP_IN, 6'h00, 8'h00, 1'b0, 1'b0, 8'h00);
    {timer0_evt, timer1_evt, timer2_evt, ext_irq_evt, pin_chg_evt} = '0;
    {port_b_pins, port_c_pins, port_d_pins, port_e_pins} = 32'h96ff3cff;
    {spi_status_live, acomp_level, acomp_evt} = 4'ha;
    // table of reads, writes, bit ops, skips and flags; writes keep reserved bits zero and a write to reserved 0x01 is flagged and stores nothing
    add(0, IOSAD_OP_OUT, 8'h05, 3'h0, 8'ha5, 8'ha5, 0);
    add(0, IOSAD_OP_IN, 8'h05, 3'h0, 8'h00, 8'ha5, 0);
    add(1, IOSAD_OP_IN, 8'h25, 3'h0, 8'h00, 8'ha5, 0);
    add(1, IOSAD_OP_OUT, 8'h24, 3'h0, 8'h3c, 8'h3c, 0);
    add(0, IOSAD_OP_SET_BIT, 8'h04, 3'h0, 8'h00, 8'h3d, 0);
    add(0, IOSAD_OP_CLR_BIT, 8'h04, 3'h2, 8'h00, 8'h39, 0);
    add(0, IOSAD_OP_SKIP_HIGH, 8'h04, 3'h3, 8'h00, 8'h03, 0);
    add(0, IOSAD_OP_SKIP_LOW, 8'h04, 3'h3, 8'h00, 8'h02, 0);
    add(0, IOSAD_OP_SKIP_LOW, 8'h04, 3'h2, 8'h00, 8'h03, 0);
    add(0, IOSAD_OP_SKIP_HIGH, 8'h03, 3'h7, 8'h00, 8'h03, 0);
    add(0, IOSAD_OP_IN, 8'h06, 3'h0, 8'h00, 8'h7f, 0);
    add(1, IOSAD_OP_IN, 8'h29, 3'h0, 8'h00, 8'h3c, 0);
    add(0, IOSAD_OP_IN, 8'h0c, 3'h0, 8'h00, 8'h0f, 0);
    add(0, IOSAD_OP_OUT, 8'h0e, 3'h0, 8'hff, 8'h0f, 0);
    add(0, IOSAD_OP_OUT, 8'h01, 3'h0, 8'hff, 8'h00, 1);
    add(0, IOSAD_OP_IN, 8'h01, 3'h0, 8'h00, 8'h00, 0);
    add(0, IOSAD_OP_IN, 8'h15, 3'h0, 8'h00, 8'h07, 0);
    add(0, IOSAD_OP_IN, 8'h1c, 3'h0, 8'h00, 8'h03, 0);
    add(0, IOSAD_OP_IN, 8'h1b, 3'h0, 8'h00, 8'h07, 0);
    add(0, IOSAD_OP_IN, 8'h30, 3'h0, 8'h00, 8'h30, 0);
    add(0, IOSAD_OP_IN, 8'h2d, 3'h0, 8'h00, 8'h80, 0);
    add(0, IOSAD_OP_OUT, 8'h16, 3'h0, 8'h01, 8'h26, 0);
    add(0, IOSAD_OP_OUT, 8'h16, 3'h0, 8'h00, 8'h26, 0);
    add(0, IOSAD_OP_CLR_BIT, 8'h16, 3'h5, 8'h00, 8'h26, 0);
    add(0, IOSAD_OP_SET_BIT, 8'h16, 3'h1, 8'h00, 8'h24, 0);
    add(0, IOSAD_OP_SET_BIT, 8'h25, 3'h0, 8'h00, 8'h00, 1);
    add(0, IOSAD_OP_SKIP_HIGH, 8'h2c, 3'h0, 8'h00, 8'h02, 1);
    add(1, IOSAD_OP_IN, 8'h10, 3'h0, 8'h00, 8'h00, 1);
    // store below the i/o window must not wrap onto 0x30
    add(1, IOSAD_OP_OUT, 8'h10, 3'h0, 8'h55, 8'h10, 1);
    add(1, IOSAD_OP_OUT, 8'h80, 3'h0, 8'h77, 8'h77, 0);
    add(1, IOSAD_OP_IN, 8'h80, 3'h0, 8'h00, 8'h77, 0);
    add(1, IOSAD_OP_IN, 8'hff, 3'h0, 8'h00, 8'ha5, 0);
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    // one-cycle set pulse on every flag source before the table runs
    {timer0_evt, timer1_evt, timer2_evt, ext_irq_evt, pin_chg_evt} = '1;
    acomp_evt = 1'b1;
    @(posedge clk_sys);
    #1;
    {timer0_evt, timer1_evt, timer2_evt, ext_irq_evt, pin_chg_evt} = '0;
    acomp_evt = 1'b0;
    @(posedge clk_sys);
    #1;
    foreach (rows[i])
    begin
      io_bit = rows[i].bit_no;
      put(!rows[i].is_mem, rows[i].op, rows[i].addr[5:0], rows[i].wdata,
        rows[i].is_mem, rows[i].op == IOSAD_OP_OUT, rows[i].addr);
      @(posedge clk_sys);
      #1;
      {io_valid, mem_valid} = 2'h0;
      watch();
      ia = rows[i].is_mem ? rows[i].addr - 8'h20 : rows[i].addr;
      if (rows[i].op == IOSAD_OP_IN)
        got = rd_val;
      else if (rows[i].op inside {IOSAD_OP_SKIP_HIGH, IOSAD_OP_SKIP_LOW})
        got = {6'h0, skip_tk};
      else
        got = rows[i].addr >= 8'h60 ? ext_wdata : io_reg_image[ia[5:0]];
      chk8(got, rows[i].exp);
      chk1(err_seen, rows[i].exp_err);
      chk1(ext_seen, rows[i].is_mem && rows[i].addr >= 8'h60);
      $display("row %0d done", i);
    end
    // ****************************************************************
    // awkward cases
    // ****************************************************************
    // back to back, and a same-cycle load/store that must lose
    put(1'b1, IOSAD_OP_OUT, 6'h1e, 8'h5a, 1'b0, 1'b0, 8'h00);
    @(posedge clk_sys);
    #1;
    put(1'b1, IOSAD_OP_IN, 6'h1e, 8'hee, 1'b1, 1'b1, 8'h2a);
    @(posedge clk_sys);
    #1;
    {io_valid, mem_valid} = 2'h0;
    watch();
    chk8(rd_val, 8'h5a);
    chk8(io_reg_image[6'h0a], 8'h00);
    $display("back to back done");
    // request in the cycle after an extended load is dropped
    put(1'b0, IOSAD_OP_IN, 6'h00, 8'h00, 1'b1, 1'b0, 8'h90);
    @(posedge clk_sys);
    #1;
    put(1'b1, IOSAD_OP_OUT, 6'h1e, 8'h11, 1'b0, 1'b0, 8'h00);
    @(posedge clk_sys);
    #1;
    io_valid = 1'b0;
    watch();
    chk8(rd_val, 8'hca);
    chk8(io_reg_image[6'h1e], 8'h5a);
    $display("extended load hold-off done");
    // reset in mid-run clears the stored image
    rst = 1'b1;
    @(posedge clk_sys);
    #1;
    chk8(io_reg_image[6'h05], 8'h00);
    chk1(rd_valid, 1'b0);
    rst = 1'b0;
    // first request right after release sees the cleared flags
    put(1'b1, IOSAD_OP_IN, 6'h15, 8'h00, 1'b0, 1'b0, 8'h00);
    @(posedge clk_sys);
    #1;
    io_valid = 1'b0;
    watch();
    chk8(rd_val, 8'h00);
    $display("mid-run reset done");
    print_verdict();
  end
endmodule
